// ---- shared/smd_pkg.sv ----
// constants, types and register map of the strap mode decoder
package smd_pkg;

   // timing
   localparam int unsigned CLOCK_MHZ = 100;
   localparam int unsigned PROBE_TIME_NS = 1000;
   localparam int unsigned PROBE_CYCLES = (PROBE_TIME_NS * CLOCK_MHZ) / 1000;
   localparam int unsigned PROBE_CNT_W = 8;
   localparam logic [PROBE_CNT_W-1:0] PROBE_LAST = PROBE_CNT_W'(PROBE_CYCLES - 1);
   localparam logic [1:0] STABLE_AGREE = 2'h2;

   // strap pin positions
   localparam int unsigned NUM_STRAPS = 4;
   localparam int unsigned PIN_MODE = 0;
   localparam int unsigned PIN_AMPL = 1;
   localparam int unsigned PIN_EDGE = 2;
   localparam int unsigned PIN_CAL = 3;
   // pull held on each pin while it serves the serial interface
   localparam logic [NUM_STRAPS-1:0] SERIAL_PULL_UP = 4'h8;

   // register bus
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam logic [ADDR_W-1:0] REG_STATUS = 8'h00;
   localparam logic [ADDR_W-1:0] REG_CONTROL = 8'h04;
   localparam logic [ADDR_W-1:0] REG_STRAPS = 8'h08;
   localparam logic [ADDR_W-1:0] REG_EVENTS = 8'h0c;

   // field positions
   localparam int unsigned STATUS_CFG_LSB = 0;
   localparam int unsigned STATUS_VALID_BIT = 8;
   localparam int unsigned STATUS_SERIAL_BIT = 9;
   localparam int unsigned CTRL_APPLY_BIT = 0;
   localparam int unsigned EV_CHANGED_BIT = 0;
   localparam int unsigned EV_AMPL_FLOAT_BIT = 1;
   localparam int unsigned EV_COUNT_LSB = 8;
   localparam int unsigned EV_COUNT_W = 8;

   // reset values
   localparam logic CTRL_APPLY_RESET = 1'b1;

   typedef enum logic [1:0] {
      SMD_STRAP_LOW,
      SMD_STRAP_HIGH,
      SMD_STRAP_FLOAT
   } smd_strap_e;

   typedef struct packed {
      logic ext_mode;
      logic fsr_large;
      logic swing_large;
      logic ddr;
      logic launch_rising;
      logic cal_long;
      logic dual_edge;
   } smd_config_s;

   typedef struct packed {
      logic clk;
      logic data;
      logic select_n;
   } smd_serial_s;

   localparam smd_config_s CONFIG_RESET = '0;
   localparam smd_serial_s SERIAL_IDLE = 3'h1;

endpackage

// ---- hw/smd_sync2.sv ----
// two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ns
`default_nettype none
module smd_sync2 #(
   parameter int unsigned WIDTH = 1
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rstn,
   // levels
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);

   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] sync_r;

   always_ff @(posedge i_clock or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         meta_r <= '0;
         sync_r <= '0;
      end
      else
      begin
         meta_r <= i_async;
         sync_r <= meta_r;
      end
   end

   assign o_sync = sync_r;

endmodule
`default_nettype wire

// ---- hw/smd_strap_sense.sv ----
// resolves one strap pin into low, high or floating by toggling its weak pull
`timescale 1ns/1ns
`default_nettype none
module smd_strap_sense (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rstn,
   // probe control
   input wire logic i_tick,
   input wire logic i_pull_up,
   input wire logic i_level,
   // result
   output smd_pkg::smd_strap_e o_state,
   output logic o_valid
);

   logic up_r;
   logic have_up_r;
   logic [1:0] agree_r;
   smd_pkg::smd_strap_e cand_r;
   smd_pkg::smd_strap_e state_r;
   logic valid_r;

   wire pair_done = i_tick && !i_pull_up && have_up_r;
   // pin follows the pull only when nothing drives it
   wire raw_ok = !(!up_r && i_level);
   wire smd_pkg::smd_strap_e raw_state = (up_r && i_level) ? smd_pkg::SMD_STRAP_HIGH :
                                        (!up_r && !i_level) ? smd_pkg::SMD_STRAP_LOW :
                                        smd_pkg::SMD_STRAP_FLOAT;
   wire same = raw_state == cand_r;
   // widened by one bit so a saturated agree count cannot wrap below the threshold
   wire settle = same && (({1'b0, agree_r} + 3'h1) >= {1'b0, smd_pkg::STABLE_AGREE});

   always_ff @(posedge i_clock or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         up_r <= 1'b0;
         have_up_r <= 1'b0;
      end
      else if (i_tick && i_pull_up)
      begin
         up_r <= i_level;
         have_up_r <= 1'b1;
      end
   end

   // a level is accepted only after agreeing probe pairs, so a bounce never lands
   always_ff @(posedge i_clock or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         cand_r <= smd_pkg::SMD_STRAP_LOW;
         agree_r <= 2'h0;
      end
      else if (pair_done && raw_ok)
      begin
         cand_r <= raw_state;
         agree_r <= same ? ((agree_r == 2'h3) ? agree_r : agree_r + 2'h1) : 2'h1;
      end
   end

   always_ff @(posedge i_clock or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         state_r <= smd_pkg::SMD_STRAP_LOW;
         valid_r <= 1'b0;
      end
      else if (pair_done && raw_ok && settle)
      begin
         state_r <= raw_state;
         valid_r <= 1'b1;
      end
   end

   assign o_state = state_r;
   assign o_valid = valid_r;

endmodule
`default_nettype wire

// ---- hw/smd_strap_mode_decoder.sv ----
// strap mode decoder: pin-controlled settings or serial pin reassignment
`timescale 1ns/1ns
`default_nettype none
module smd_strap_mode_decoder (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rstn,
   // register port
   input wire logic [smd_pkg::ADDR_W-1:0] i_addr,
   input wire logic [smd_pkg::DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [smd_pkg::DATA_W-1:0] o_rdata,
   // strap pins
   input wire logic [smd_pkg::NUM_STRAPS-1:0] i_strap_pin,
   output logic [smd_pkg::NUM_STRAPS-1:0] o_pull_up,
   // decoded configuration
   output smd_pkg::smd_config_s o_config,
   output logic o_config_valid,
   // serial interface lines
   output smd_pkg::smd_serial_s o_serial,
   output logic o_serial_active
);

   // probe timebase
   logic [smd_pkg::PROBE_CNT_W-1:0] probe_cnt_r;
   logic tick_r;
   logic phase_r;

   always_ff @(posedge i_clock or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         probe_cnt_r <= '0;
         tick_r <= 1'b0;
      end
      else if (probe_cnt_r == smd_pkg::PROBE_LAST)
      begin
         probe_cnt_r <= '0;
         tick_r <= 1'b1;
      end
      else
      begin
         probe_cnt_r <= probe_cnt_r + 1'b1;
         tick_r <= 1'b0;
      end
   end

   // pull phase flips only on a tick, leaving a full period for the pin to settle
   always_ff @(posedge i_clock or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         phase_r <= 1'b1;
      end
      else if (tick_r)
      begin
         phase_r <= !phase_r;
      end
   end

   // per-pin synchroniser and three-state sense
   logic [smd_pkg::NUM_STRAPS-1:0] pin_sync;
   logic [smd_pkg::NUM_STRAPS-1:0] pin_valid;
   logic [smd_pkg::NUM_STRAPS-1:0] pull_r;
   smd_pkg::smd_strap_e pin_state [smd_pkg::NUM_STRAPS];
   logic ext_mode_r;

   smd_sync2 #(
      .WIDTH(smd_pkg::NUM_STRAPS)
   ) u_sync (
      .i_clock(i_clock),
      .i_rstn(i_rstn),
      .i_async(i_strap_pin),
      .o_sync(pin_sync)
   );

   genvar gi;
   generate
      for (gi = 0; gi < smd_pkg::NUM_STRAPS; gi = gi + 1)
      begin : g_pin
         // in serial mode the function pins hold a fixed pull and stop probing
         wire serial_pin = ext_mode_r && (gi != smd_pkg::PIN_MODE);

         always_ff @(posedge i_clock or negedge i_rstn)
         begin
            if (!i_rstn)
            begin
               pull_r[gi] <= 1'b1;
            end
            else
            begin
               pull_r[gi] <= serial_pin ? smd_pkg::SERIAL_PULL_UP[gi] : phase_r;
            end
         end

         smd_strap_sense u_sense (
            .i_clock(i_clock),
            .i_rstn(i_rstn),
            .i_tick(tick_r && !serial_pin),
            .i_pull_up(pull_r[gi]),
            .i_level(pin_sync[gi]),
            .o_state(pin_state[gi]),
            .o_valid(pin_valid[gi])
         );
      end
   endgenerate

   assign o_pull_up = pull_r;

   // decode of resolved straps
   wire smd_pkg::smd_strap_e mode_st = pin_state[smd_pkg::PIN_MODE];
   wire smd_pkg::smd_strap_e ampl_st = pin_state[smd_pkg::PIN_AMPL];
   wire smd_pkg::smd_strap_e edge_st = pin_state[smd_pkg::PIN_EDGE];
   wire smd_pkg::smd_strap_e cal_st = pin_state[smd_pkg::PIN_CAL];

   wire mode_float = mode_st == smd_pkg::SMD_STRAP_FLOAT;
   wire pin_ctrl = !mode_float;
   wire fsr_large = pin_ctrl && (mode_st == smd_pkg::SMD_STRAP_HIGH);
   // a floating amplitude strap has no meaning; it falls back to the small swing
   wire swing_large = pin_ctrl && (ampl_st == smd_pkg::SMD_STRAP_HIGH);
   wire ampl_float = pin_ctrl && (ampl_st == smd_pkg::SMD_STRAP_FLOAT);
   wire ddr = pin_ctrl && (edge_st == smd_pkg::SMD_STRAP_FLOAT);
   wire launch_rising = pin_ctrl && !ddr && (edge_st == smd_pkg::SMD_STRAP_HIGH);
   wire cal_long = pin_ctrl && (cal_st == smd_pkg::SMD_STRAP_HIGH);
   wire dual_edge = pin_ctrl && (cal_st == smd_pkg::SMD_STRAP_FLOAT);

   // in serial mode only the mode pin must be settled; the others carry traffic
   wire mode_valid = pin_valid[smd_pkg::PIN_MODE];
   wire all_valid = mode_valid && (mode_float || (&pin_valid));

   smd_pkg::smd_config_s cfg_nxt;
   always_comb
   begin
      cfg_nxt = smd_pkg::CONFIG_RESET;
      cfg_nxt.ext_mode = mode_float;
      cfg_nxt.fsr_large = fsr_large;
      cfg_nxt.swing_large = swing_large;
      cfg_nxt.ddr = ddr;
      cfg_nxt.launch_rising = launch_rising;
      cfg_nxt.cal_long = cal_long;
      cfg_nxt.dual_edge = dual_edge;
   end

   // software-visible control and events
   logic apply_en_r;
   logic ev_changed_r;
   logic ev_ampl_float_r;
   logic [smd_pkg::EV_COUNT_W-1:0] ev_count_r;
   smd_pkg::smd_config_s config_r;
   logic config_valid_r;

   wire wr_control = i_wr && (i_addr == smd_pkg::REG_CONTROL);
   wire wr_events = i_wr && (i_addr == smd_pkg::REG_EVENTS);
   wire clr_changed = wr_events && i_wdata[smd_pkg::EV_CHANGED_BIT];
   wire clr_ampl_float = wr_events && i_wdata[smd_pkg::EV_AMPL_FLOAT_BIT];
   wire apply_now = apply_en_r && all_valid;
   wire cfg_change = apply_now && config_valid_r && (cfg_nxt != config_r);
   wire ampl_float_seen = apply_now && ampl_float;

   always_ff @(posedge i_clock or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         apply_en_r <= smd_pkg::CTRL_APPLY_RESET;
      end
      else if (wr_control)
      begin
         apply_en_r <= i_wdata[smd_pkg::CTRL_APPLY_BIT];
      end
   end

   // configuration is only replaced as a whole, never field by field
   always_ff @(posedge i_clock or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         config_r <= smd_pkg::CONFIG_RESET;
         config_valid_r <= 1'b0;
      end
      else if (apply_now)
      begin
         config_r <= cfg_nxt;
         config_valid_r <= 1'b1;
      end
   end

   always_ff @(posedge i_clock or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         ext_mode_r <= 1'b0;
      end
      else if (mode_valid)
      begin
         ext_mode_r <= mode_float;
      end
   end

   // sticky events: a new event in the clearing cycle survives the clear
   always_ff @(posedge i_clock or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         ev_changed_r <= 1'b0;
         ev_ampl_float_r <= 1'b0;
         ev_count_r <= '0;
      end
      else
      begin
         ev_changed_r <= cfg_change || (ev_changed_r && !clr_changed);
         ev_ampl_float_r <= ampl_float_seen || (ev_ampl_float_r && !clr_ampl_float);
         if (cfg_change && (ev_count_r != '1))
         begin
            ev_count_r <= ev_count_r + 1'b1;
         end
      end
   end

   // serial lines pass through only while the mode pin floats
   smd_pkg::smd_serial_s serial_r;
   wire serial_active = ext_mode_r && config_valid_r;

   always_ff @(posedge i_clock or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         serial_r <= smd_pkg::SERIAL_IDLE;
      end
      else if (serial_active)
      begin
         serial_r.clk <= pin_sync[smd_pkg::PIN_AMPL];
         serial_r.data <= pin_sync[smd_pkg::PIN_EDGE];
         serial_r.select_n <= pin_sync[smd_pkg::PIN_CAL];
      end
      else
      begin
         serial_r <= smd_pkg::SERIAL_IDLE;
      end
   end

   // read data
   logic [smd_pkg::DATA_W-1:0] rdata_r;
   logic [smd_pkg::DATA_W-1:0] status_word;
   logic [smd_pkg::DATA_W-1:0] control_word;
   logic [smd_pkg::DATA_W-1:0] straps_word;
   logic [smd_pkg::DATA_W-1:0] events_word;
   logic [smd_pkg::DATA_W-1:0] rd_mux;

   always_comb
   begin
      status_word = '0;
      status_word[smd_pkg::STATUS_CFG_LSB +: $bits(smd_pkg::smd_config_s)] = config_r;
      status_word[smd_pkg::STATUS_VALID_BIT] = config_valid_r;
      status_word[smd_pkg::STATUS_SERIAL_BIT] = serial_active;
      control_word = '0;
      control_word[smd_pkg::CTRL_APPLY_BIT] = apply_en_r;
      straps_word = '0;
      for (int i = 0; i < smd_pkg::NUM_STRAPS; i++)
      begin
         straps_word[2*i +: 2] = pin_state[i];
         straps_word[2*smd_pkg::NUM_STRAPS + i] = pin_valid[i];
      end
      events_word = '0;
      events_word[smd_pkg::EV_CHANGED_BIT] = ev_changed_r;
      events_word[smd_pkg::EV_AMPL_FLOAT_BIT] = ev_ampl_float_r;
      events_word[smd_pkg::EV_COUNT_LSB +: smd_pkg::EV_COUNT_W] = ev_count_r;
   end

   assign rd_mux = (i_addr == smd_pkg::REG_STATUS) ? status_word :
                   (i_addr == smd_pkg::REG_CONTROL) ? control_word :
                   (i_addr == smd_pkg::REG_STRAPS) ? straps_word :
                   (i_addr == smd_pkg::REG_EVENTS) ? events_word : '0;

   // data stand for exactly the cycle after the read strobe
   always_ff @(posedge i_clock or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         rdata_r <= '0;
      end
      else
      begin
         rdata_r <= i_rd ? rd_mux : '0;
      end
   end

   assign o_rdata = rdata_r;
   assign o_config = config_r;
   assign o_config_valid = config_valid_r;
   assign o_serial = serial_r;
   assign o_serial_active = serial_active;

endmodule
`default_nettype wire

// ---- test/smd_strap_mode_decoder_sva.sv ----
// assertions on the strap mode decoder ports
`timescale 1ns/1ns
`default_nettype none
module smd_strap_mode_decoder_sva (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rstn,
   // strap pins
   input wire logic [smd_pkg::NUM_STRAPS-1:0] i_strap_pin,
   input wire logic [smd_pkg::NUM_STRAPS-1:0] o_pull_up,
   // decoded outputs
   input wire smd_pkg::smd_config_s o_config,
   input wire logic o_config_valid,
   input wire smd_pkg::smd_serial_s o_serial,
   input wire logic o_serial_active
);
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_rstn);

   // serial mode settled long enough for the sync pipe to hold live pin values
   sequence ser_on;
      o_serial_active [*5];
   endsequence

   idle_serial_a: assert property (!o_serial_active |-> o_serial == smd_pkg::SERIAL_IDLE)
      else $error("serial lines moved while inactive");
   active_gate_a: assert property (o_serial_active == (o_config.ext_mode && o_config_valid))
      else $error("serial active disagrees with mode");
   ext_fields_a: assert property (o_config.ext_mode |-> o_config[5:0] == 6'h00)
      else $error("pin settings leak into serial mode");
   serial_path_a: assert property (ser_on |-> o_serial == {$past(i_strap_pin[1], 3),
      $past(i_strap_pin[2], 3), $past(i_strap_pin[3], 3)})
      else $error("serial lines do not follow straps");
   serial_pull_a: assert property (ser_on |-> o_pull_up[3:1] == smd_pkg::SERIAL_PULL_UP[3:1])
      else $error("serial pin pulls wrong");
   ddr_edge_a: assert property (o_config.ddr |-> !o_config.launch_rising)
      else $error("edge select active in double rate");
   dual_delay_a: assert property (o_config.dual_edge |-> !o_config.cal_long)
      else $error("dual edge with long delay");
   reset_cfg_a: assert property (!o_config_valid |-> o_config == smd_pkg::CONFIG_RESET)
      else $error("config applied before valid");
   valid_hold_a: assert property (o_config_valid |=> o_config_valid)
      else $error("config valid dropped");
endmodule

bind smd_strap_mode_decoder smd_strap_mode_decoder_sva u_sva (
   .i_clock,
   .i_rstn,
   .i_strap_pin,
   .o_pull_up,
   .o_config,
   .o_config_valid,
   .o_serial,
   .o_serial_active
);
`default_nettype wire

// ---- test/smd_board_model.sv ----
// board strap model: each pin held low, held high or left floating on its weak pull
`timescale 1ns/1ns
`default_nettype none
module smd_board_model (
   // weak pulls from the decoder
   input wire logic [smd_pkg::NUM_STRAPS-1:0] i_pull_up,
   // per pin two bits: 0 low, 1 high, 2 floating
   input wire logic [2*smd_pkg::NUM_STRAPS-1:0] i_state,
   // pin levels
   output logic [smd_pkg::NUM_STRAPS-1:0] o_pin
);
   genvar g;
   for (g = 0; g < smd_pkg::NUM_STRAPS; g++)
   begin : g_pin
      // an undriven pin settles to the weak pull, never to a stale level
      assign o_pin[g] = i_state[2*g+1] ? i_pull_up[g] : i_state[2*g];
   end
endmodule
`default_nettype wire

// ---- test/smd_strap_mode_decoder_tb.sv ----
// self-checking bench for the strap mode decoder
`timescale 1ns/1ns
`default_nettype none
module smd_strap_mode_decoder_tb;
   logic i_clock = 1'b0;
   logic i_rstn = 1'b0;
   logic [smd_pkg::ADDR_W-1:0] i_addr = 8'h00;
   logic [smd_pkg::DATA_W-1:0] i_wdata = 32'h0;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [smd_pkg::DATA_W-1:0] o_rdata;
   logic [3:0] i_strap_pin;
   logic [3:0] o_pull_up;
   smd_pkg::smd_config_s o_config;
   logic o_config_valid;
   smd_pkg::smd_serial_s o_serial;
   logic o_serial_active;
   logic [7:0] state = 8'h00;
   logic [7:0] tbl[4] = '{8'h00, 8'h55, 8'ha4, 8'h49};
   logic rd_pend = 1'b0;
   logic [63:0] exp_q[$];
   logic [63:0] note;
   int num_errors = 0;
   int checked = 0;
   int seed = 32'h68aeca4a;
   int r;

   always #5 i_clock = ~i_clock;

   smd_strap_mode_decoder DUT (.i_clock, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd,
      .o_rdata, .i_strap_pin, .o_pull_up, .o_config, .o_config_valid, .o_serial,
      .o_serial_active);
   smd_board_model board (.i_pull_up(o_pull_up), .i_state(state), .o_pin(i_strap_pin));

   task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
      checked++;
      if ((got & m) !== (exp & m))
      begin
         num_errors++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_ser(input smd_pkg::smd_serial_s got, input smd_pkg::smd_serial_s exp);
      chk_rd({29'h0, got}, {29'h0, exp}, 32'h7);
   endtask

   task automatic close_out;
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      @(posedge i_clock);
      i_rd <= 1'b1;
      i_addr <= a;
      exp_q.push_back({m, e});
      @(posedge i_clock);
      i_rd <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clock);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clock);
      i_wr <= 1'b0;
   endtask

   // levels must stay put well past the two agreeing probe pairs
   task automatic strap(input logic [7:0] s);
      @(posedge i_clock);
      state <= s;
      repeat (1000) @(posedge i_clock);
   endtask

   // status word for a strap set {cal, edge, amp, mode}
   function automatic logic [31:0] stat(input logic [7:0] s);
      if (s[1:0] == 2'h2)
         return 32'h340;
      return {22'h0, 4'h4, s[1:0] == 2'h1, s[3:2] == 2'h1, s[5:4] == 2'h2,
         s[5:4] == 2'h1, s[7:6] == 2'h1, s[7:6] == 2'h2};
   endfunction

   always @(posedge i_clock) rd_pend <= i_rd;

   // read data stands only in the cycle after the strobe
   always @(negedge i_clock)
      if (rd_pend)
      begin
         note = exp_q.pop_front();
         chk_rd(o_rdata, note[31:0], note[63:32]);
      end

   initial
   begin
      repeat (20000) @(posedge i_clock);
      num_errors++;
      close_out;
   end

   initial
   begin
      repeat (12) @(posedge i_clock);
      i_rstn <= 1'b1;
      foreach (tbl[k])
      begin
         strap(tbl[k]);
         rd(smd_pkg::REG_STATUS, stat(tbl[k]), '1);
      end
      rd(smd_pkg::REG_EVENTS, 32'h2, 32'h2);
      rd(smd_pkg::REG_STRAPS, 32'h00000f49, '1);
      wr(smd_pkg::REG_EVENTS, 32'h3);
      // live floating amplitude strap sets again in the clearing cycle
      rd(smd_pkg::REG_EVENTS, 32'h2, 32'h3);
      r = $random(seed);
      wr(smd_pkg::REG_STATUS, r);
      rd(smd_pkg::REG_STATUS, stat(8'h49), '1);
      rd(8'h10, 32'h0, '1);
      wr(smd_pkg::REG_CONTROL, 32'h0);
      rd(smd_pkg::REG_CONTROL, 32'h0, 32'h1);
      strap(8'h55);
      rd(smd_pkg::REG_STATUS, stat(8'h49), '1);
      wr(smd_pkg::REG_CONTROL, 32'h1);
      strap(8'h55);
      rd(smd_pkg::REG_STATUS, stat(8'h55), '1);
      strap(8'h02);
      rd(smd_pkg::REG_STATUS, 32'h340, '1);
      repeat (8)
      begin
         r = $random(seed);
         @(posedge i_clock);
         state <= {1'b0, r[2], 1'b0, r[1], 1'b0, r[0], 2'h2};
         repeat (4) @(posedge i_clock);
         @(negedge i_clock);
         chk_ser(o_serial, {r[0], r[1], r[2]});
      end
      repeat (4) @(posedge i_clock);
      close_out;
   end
endmodule
`default_nettype wire
